// File: hdl/pcg_counter.sv
// Summary of operation
// - cancel gate: reopen restarts from load value
// - interrupt gate: reopen continues previous count
// - program gate alone: load or continue by parameter
// - pin already open: program gate opening continues
// - pin gate opening: load or continue by parameter
// - isochronous with pin gate: program gate counts next bus cycle
// - retrigger: edge latches count, reloads load value
// - retrigger acts only after program gate enabled
// - latch modes report latch value bytes 0-3
// - latch starts at reset value, gate untouched
// - direct load leaves latch value alone
// - retrigger: gate close interrupts, input stays active
// - isochronous: report last edge before sample instant
// - plain latch: start at load, exact edge count
// - plain latch: close cancels or interrupts, latches
// - level flag follows digital input level
// - wide interface: running count in bytes 8-11
// - sync edge loads when gated and enabled
// - once-only first edge, periodic every edge
// - sync flag sticky until status clear request
// - isochronous sync flag: edge since previous instant
// - feedback groups captured together, always consistent
// - internal gate is pin gate AND program gate
// - program gate opens on rising control bit
// - counter wraps at limits without losing pulses
module pcg_counter
  import pcg_pkg::*;
(
  // clock and reset
  input  wire logic     clk_sys,
  input  wire logic     srst,
  // parameter assignment and control interface
  input  wire pcg_cfg_t cfg,
  input  wire pcg_ctrl_t ctrl,
  input  wire logic     sample_instant,
  // pins
  input  wire logic     count_pulse_pin,
  input  wire logic     direction_pin,
  input  wire logic     digital_input_pin,
  input  wire logic     supply_short_pin,
  // feedback interface
  output pcg_fb_t       feedback
);

  // pin synchronisers: stage 1 is read only by stage 2
  logic [1:0] pulse_sync;
  logic [1:0] dir_sync;
  logic [1:0] di_sync;
  logic [1:0] short_sync;
  logic       pulse_prev;
  logic       di_prev;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pulse_sync <= 2'h0;
      dir_sync   <= 2'h0;
      di_sync    <= 2'h0;
      short_sync <= 2'h0;
      pulse_prev <= 1'b0;
      di_prev    <= 1'b0;
    end else begin
      pulse_sync <= {pulse_sync[0], count_pulse_pin};
      dir_sync   <= {dir_sync[0], direction_pin};
      di_sync    <= {di_sync[0], digital_input_pin};
      short_sync <= {short_sync[0], supply_short_pin};
      pulse_prev <= pulse_sync[1];
      di_prev    <= di_sync[1];
    end
  end

  logic pulse_evt;
  logic count_up;
  logic di_level;
  logic di_rise;
  logic pin_level;
  logic pin_rise;

  assign pulse_evt = pulse_sync[1] & ~pulse_prev;
  assign count_up  = ~dir_sync[1];
  assign di_level  = di_sync[1];
  assign di_rise   = di_sync[1] & ~di_prev;

  logic use_pin;
  logic is_retrig;
  logic is_latch;
  logic is_sync;

  assign use_pin   = (cfg.di_function == PCG_DI_PIN_GATE);
  assign is_retrig = (cfg.di_function == PCG_DI_LATCH_RETRIG);
  assign is_latch  = (cfg.di_function == PCG_DI_LATCH);
  assign is_sync   = (cfg.di_function == PCG_DI_SYNC);

  assign pin_level = di_level ^ cfg.pin_gate_inv;
  assign pin_rise  = pin_level & ~(di_prev ^ cfg.pin_gate_inv);

  // program gate
  logic prog_bit_prev;
  logic prog_gate;
  logic prog_pending;
  logic prog_open_evt;
  logic prog_rise;

  assign prog_rise = ctrl.program_gate_bit & ~prog_bit_prev;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      prog_bit_prev <= 1'b0;
    end else begin
      prog_bit_prev <= ctrl.program_gate_bit;
    end
  end

  // an isochronous open against the pin gate waits for the next bus cycle
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      prog_pending <= 1'b0;
    end else if (!ctrl.program_gate_bit) begin
      prog_pending <= 1'b0;
    end else if (prog_rise && cfg.iso_mode && use_pin && !sample_instant) begin
      prog_pending <= 1'b1;
    end else if (sample_instant) begin
      prog_pending <= 1'b0;
    end
  end

  assign prog_open_evt = ctrl.program_gate_bit && !prog_gate &&
                         ((prog_rise && !(cfg.iso_mode && use_pin && !sample_instant)) ||
                          (prog_pending && sample_instant));

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      prog_gate <= 1'b0;
    end else if (!ctrl.program_gate_bit) begin
      prog_gate <= 1'b0;
    end else if (prog_open_evt) begin
      prog_gate <= 1'b1;
    end
  end

  // internal gate
  logic gate_now;
  logic gate_prev;
  logic gate_open;
  logic ever_opened;
  logic load_on_open;

  always_comb begin
    gate_now = prog_gate & (use_pin ? pin_level : 1'b1);
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      gate_prev   <= 1'b0;
      ever_opened <= 1'b0;
    end else begin
      gate_prev <= gate_now;
      if (gate_now) begin
        ever_opened <= 1'b1;
      end
    end
  end

  assign gate_open = gate_now & ~gate_prev;

  always_comb begin
    if (is_retrig) begin
      load_on_open = 1'b0;
    end else if (is_latch) begin
      load_on_open = !ever_opened || cfg.gate_cancel;
    end else if (use_pin) begin
      load_on_open = pin_rise && cfg.gate_cancel;
    end else begin
      load_on_open = cfg.gate_cancel;
    end
  end

  // load value
  logic [31:0] load_value;
  logic        load_bad;
  logic        load_error;
  logic        load_busy;

  assign load_bad = ($signed(ctrl.load_value) < LOAD_MIN) ||
                    ($signed(ctrl.load_value) > LOAD_MAX);

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      load_value <= LOAD_VALUE_RST;
      load_error <= 1'b0;
      load_busy  <= 1'b0;
    end else begin
      load_busy <= (ctrl.load_direct | ctrl.load_prepare) & ~load_bad;
      if (ctrl.load_direct || ctrl.load_prepare) begin
        load_error <= load_bad;
        if (!load_bad) begin
          load_value <= ctrl.load_value;
        end
      end
    end
  end

  // digital input events
  logic retrig_armed;
  logic retrig_evt;
  logic latch_evt;
  logic sync_armed;
  logic sync_evt;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      retrig_armed <= 1'b0;
    end else if (is_retrig && prog_gate) begin
      retrig_armed <= 1'b1;
    end else if (!is_retrig) begin
      retrig_armed <= 1'b0;
    end
  end

  assign retrig_evt = is_retrig && retrig_armed && di_rise;
  assign latch_evt  = (is_latch && di_rise) || retrig_evt;
  assign sync_evt   = is_sync && di_rise && prog_gate &&
                      ctrl.sync_enable_bit && sync_armed;

  // once-only use is rearmed by taking the enable bit away
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sync_armed <= 1'b1;
    end else if (!ctrl.sync_enable_bit) begin
      sync_armed <= 1'b1;
    end else if (sync_evt && !cfg.sync_periodic) begin
      sync_armed <= 1'b0;
    end
  end

  // counter
  logic [31:0] count;
  logic [31:0] next_count;
  logic        step;
  logic        wrap_high;
  logic        wrap_low;
  logic        cross_zero;

  assign step      = gate_now && pulse_evt;
  assign wrap_high = step && count_up && (count == COUNT_HIGH);
  assign wrap_low  = step && !count_up && (count == COUNT_LOW);
  assign cross_zero = step && (count_up ? (count == 32'hFFFF_FFFF) :
                                          (count == 32'h0000_0000));

  always_comb begin
    if (ctrl.load_direct && !load_bad) begin
      next_count = ctrl.load_value;
    end else if (retrig_evt || sync_evt) begin
      next_count = load_value;
    end else if (gate_open && load_on_open) begin
      next_count = load_value;
    end else if (step) begin
      next_count = count_up ? count + 32'h0000_0001 : count - 32'h0000_0001;
    end else begin
      next_count = count;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      count <= COUNT_VALUE_RST;
    end else begin
      count <= next_count;
    end
  end

  // latch value changes only on an input edge
  logic [31:0] latch_value;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      latch_value <= LATCH_VALUE_RST;
    end else if (latch_evt) begin
      latch_value <= count;
    end
  end

  // sticky status; a set in the clearing cycle wins
  logic sync_done;
  logic sync_window;
  logic high_flag;
  logic low_flag;
  logic zero_flag;
  logic dir_up;
  logic dir_down;
  logic take;

  assign take = !cfg.iso_mode || sample_instant;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sync_done <= 1'b0;
    end else if (sync_evt) begin
      sync_done <= 1'b1;
    end else if (ctrl.status_clear_request) begin
      sync_done <= 1'b0;
    end
  end

  // edge seen since the previous sample instant
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sync_window <= 1'b0;
    end else if (take) begin
      sync_window <= 1'b0;
    end else if (sync_evt) begin
      sync_window <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      high_flag <= 1'b0;
      low_flag  <= 1'b0;
      zero_flag <= 1'b0;
    end else begin
      high_flag <= wrap_high | (high_flag & ~ctrl.status_clear_request);
      low_flag  <= wrap_low | (low_flag & ~ctrl.status_clear_request);
      zero_flag <= cross_zero | (zero_flag & ~ctrl.status_clear_request);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      dir_up   <= 1'b0;
      dir_down <= 1'b0;
    end else if (step) begin
      dir_up   <= count_up;
      dir_down <= ~count_up;
    end
  end

  // feedback image, every group taken in one cycle
  pcg_fb_t next_feedback;

  always_comb begin
    next_feedback = '0;
    next_feedback.count_or_latch_value = (is_latch || is_retrig) ?
                                         latch_value : count;
    next_feedback.error_and_load_status.encoder_supply_fault = short_sync[1];
    next_feedback.error_and_load_status.parameter_fault = cfg.pin_gate_inv && !use_pin;
    next_feedback.error_and_load_status.status_clear_active = ctrl.status_clear_request;
    next_feedback.error_and_load_status.load_error = load_error;
    next_feedback.error_and_load_status.load_in_progress = load_busy;
    next_feedback.direction_gate_input_status.counting_down_flag = dir_down;
    next_feedback.direction_gate_input_status.counting_up_flag = dir_up;
    next_feedback.direction_gate_input_status.input_level_flag = di_level;
    next_feedback.direction_gate_input_status.internal_gate_flag = gate_now;
    next_feedback.limit_zero_sync_status.zero_crossing_flag = zero_flag;
    next_feedback.limit_zero_sync_status.low_limit_flag = low_flag;
    next_feedback.limit_zero_sync_status.high_limit_flag = high_flag;
    next_feedback.limit_zero_sync_status.sync_done_flag = cfg.iso_mode ?
                                         (sync_window | sync_evt) : sync_done;
    next_feedback.spare_feedback_byte = SPARE_BYTE_RST;
    next_feedback.running_count_wide = cfg.wide_interface ? count : 32'h0000_0000;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      feedback <= '0;
    end else if (take) begin
      feedback <= next_feedback;
    end
  end

endmodule

// File: hdl/pcg_pkg.sv
package pcg_pkg;

  // feedback layout: byte offsets of each consistent group
  localparam int unsigned FB_VALUE_OFS  = 0;
  localparam int unsigned FB_ERROR_OFS  = 4;
  localparam int unsigned FB_STATUS_OFS = 5;
  localparam int unsigned FB_LIMIT_OFS  = 6;
  localparam int unsigned FB_SPARE_OFS  = 7;
  localparam int unsigned FB_WIDE_OFS   = 8;

  // values after reset
  localparam logic [31:0] LOAD_VALUE_RST  = 32'h0000_0000;
  localparam logic [31:0] COUNT_VALUE_RST = 32'h0000_0000;
  localparam logic [31:0] LATCH_VALUE_RST = 32'h0000_0000;
  localparam logic [7:0]  SPARE_BYTE_RST  = 8'h00;

  // legal load value range, -16777216 .. +16777215
  localparam logic signed [31:0] LOAD_MIN = 32'shFF00_0000;
  localparam logic signed [31:0] LOAD_MAX = 32'sh00FF_FFFF;

  // counting limits, wrap without losing a pulse
  localparam logic [31:0] COUNT_HIGH = 32'h7FFF_FFFF;
  localparam logic [31:0] COUNT_LOW  = 32'h8000_0000;

  // what the digital input pin does
  typedef enum logic [2:0] {
    PCG_DI_INPUT,
    PCG_DI_PIN_GATE,
    PCG_DI_LATCH_RETRIG,
    PCG_DI_LATCH,
    PCG_DI_SYNC
  } pcg_di_func_t;

  // parameter assignment, static while running
  typedef struct packed {
    pcg_di_func_t di_function;
    logic         gate_cancel;     // 1: cancel, 0: interrupt
    logic         pin_gate_inv;
    logic         sync_periodic;   // 1: periodic, 0: once only
    logic         iso_mode;
    logic         wide_interface;
  } pcg_cfg_t;

  // control bits, written by the controller each bus cycle
  typedef struct packed {
    logic [31:0] load_value;
    logic        load_direct;      // one-cycle strobe
    logic        load_prepare;     // one-cycle strobe
    logic        program_gate_bit;
    logic        sync_enable_bit;
    logic        status_clear_request;
  } pcg_ctrl_t;

  typedef struct packed {
    logic       encoder_supply_fault;
    logic       rsvd6;
    logic       parameter_fault;
    logic [1:0] rsvd43;
    logic       status_clear_active;
    logic       load_error;
    logic       load_in_progress;
  } pcg_err_byte_t;

  typedef struct packed {
    logic       counting_down_flag;
    logic       counting_up_flag;
    logic [3:0] rsvd52;
    logic       input_level_flag;
    logic       internal_gate_flag;
  } pcg_dir_byte_t;

  typedef struct packed {
    logic       zero_crossing_flag;
    logic       low_limit_flag;
    logic       high_limit_flag;
    logic [3:0] rsvd41;
    logic       sync_done_flag;
  } pcg_lim_byte_t;

  // twelve feedback bytes, MSB field is byte 0
  typedef struct packed {
    logic [31:0]   count_or_latch_value;
    pcg_err_byte_t error_and_load_status;
    pcg_dir_byte_t direction_gate_input_status;
    pcg_lim_byte_t limit_zero_sync_status;
    logic [7:0]    spare_feedback_byte;
    logic [31:0]   running_count_wide;
  } pcg_fb_t;

endpackage

// File: bench/pcg_counter_sva.sv
module pcg_counter_sva
  import pcg_pkg::*;
(
  // clock and reset
  input wire logic      clk_sys,
  input wire logic      srst,
  // parameters and controls
  input wire pcg_cfg_t  cfg,
  input wire pcg_ctrl_t ctrl,
  input wire logic      sample_instant,
  // pins
  input wire logic      count_pulse_pin,
  input wire logic      direction_pin,
  input wire logic      digital_input_pin,
  input wire logic      supply_short_pin,
  // feedback
  input wire pcg_fb_t   feedback
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);

  logic pg;
  logic din;
  logic clr;
  logic ni;
  logic npin;
  logic gflag;
  logic sflag;
  assign pg    = ctrl.program_gate_bit;
  assign din   = digital_input_pin;
  assign clr   = ctrl.status_clear_request;
  // iso feedback only moves at the sample instant, so skip it here
  assign ni    = !cfg.iso_mode;
  assign npin  = ni && cfg.di_function != PCG_DI_PIN_GATE;
  assign gflag = feedback.direction_gate_input_status.internal_gate_flag;
  assign sflag = feedback.limit_zero_sync_status.sync_done_flag;

  sequence s_open;
    $rose(pg) ##1 pg [*2];
  endsequence
  sequence s_noclr;
    (ni && !clr) ##1 (!clr && sflag);
  endsequence

  property p_gate_open;
    (npin ##0 s_open) |-> gflag;
  endproperty
  property p_gate_close;
    (npin && !pg) [*3] |-> !gflag;
  endproperty
  property p_level;
    (ni && $stable(din)) [*6] |-> feedback.direction_gate_input_status.input_level_flag == din;
  endproperty
  property p_latch_hold;
    (ni && cfg.di_function inside {PCG_DI_LATCH, PCG_DI_LATCH_RETRIG} && $stable(din)) [*4]
      ##0 ctrl.load_direct |=> $stable(feedback.count_or_latch_value) [*3];
  endproperty
  property p_sync_hold;
    s_noclr |=> sflag;
  endproperty
  property p_sync_clr;
    (ni && clr && $stable(din)) [*6] |-> !sflag;
  endproperty
  property p_clr_active;
    (ni && clr) [*2] |-> feedback.error_and_load_status.status_clear_active;
  endproperty
  property p_count_hold;
    (ni && cfg.di_function == PCG_DI_INPUT && !pg && !ctrl.load_direct) [*4]
      |=> $stable(feedback.running_count_wide);
  endproperty
  property p_wide_eq;
    (ni && cfg.wide_interface && cfg.di_function == PCG_DI_INPUT)
      |-> feedback.count_or_latch_value == feedback.running_count_wide;
  endproperty

  a_gate_open: assert property (p_gate_open) else $error("gate flag late");
  a_gate_close: assert property (p_gate_close) else $error("gate flag stuck");
  a_level: assert property (p_level) else $error("level flag wrong");
  a_latch_hold: assert property (p_latch_hold) else $error("latch moved");
  a_sync_hold: assert property (p_sync_hold) else $error("sync flag lost");
  a_sync_clr: assert property (p_sync_clr) else $error("sync flag kept");
  a_clr_active: assert property (p_clr_active) else $error("clear flag off");
  a_count_hold: assert property (p_count_hold) else $error("count moved");
  a_wide_eq: assert property (p_wide_eq) else $error("wide count differs");
endmodule

bind pcg_counter pcg_counter_sva pcg_counter_sva_inst (
  .clk_sys, .srst, .cfg, .ctrl, .sample_instant, .count_pulse_pin,
  .direction_pin, .digital_input_pin, .supply_short_pin, .feedback
);

// File: bench/pcg_host_model.sv
module pcg_host_model
  import pcg_pkg::*;
#(
  parameter int unsigned CYCLE = 50
)(
  // clock and reset
  input  wire logic      clk_sys,
  input  wire logic      srst,
  // request from the bench
  input  wire pcg_ctrl_t req,
  // towards the block
  output pcg_ctrl_t      ctrl,
  output logic           sample_instant
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned cnt;

  // one bus transfer per clock, so the block sees requests a clock late
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ctrl <= '0;
    end else begin
      ctrl <= req;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst || cnt == CYCLE - 1) begin
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
  assign sample_instant = (cnt == CYCLE - 1) && !srst;
endmodule

// File: bench/tb_position_counter_gate_latch_sync.sv
module tb_position_counter_gate_latch_sync
  import pcg_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [1:0]  k;
    logic [31:0] v;
    logic [31:0] m;
  } pcg_note_t;

  logic        clk_sys;
  logic        srst;
  logic        sample_instant;
  logic        cp;
  logic        dir;
  logic        dip;
  logic        shrt;
  logic        chk;
  pcg_cfg_t    cfg;
  pcg_ctrl_t   req;
  pcg_ctrl_t   ctrl;
  pcg_fb_t     feedback;
  pcg_note_t   q[$];
  pcg_note_t   e;
  logic [31:0] ld_v;
  logic [31:0] n;
  int          n_errors;
  int          compares;
  int          seed;
  int          cyc;

  pcg_host_model pcg_host_model_inst (.clk_sys, .srst, .req, .ctrl, .sample_instant);
  pcg_counter pcg_counter_inst (.clk_sys, .srst, .cfg, .ctrl, .sample_instant,
    .count_pulse_pin(cp), .direction_pin(dir), .digital_input_pin(dip),
    .supply_short_pin(shrt), .feedback);

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    if (n_errors == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // reads the values from before this edge, i.e. settled ones
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (chk) begin
      e = q.pop_front();
      check(feedback[95 - 32*e.k -: 32] & e.m, e.v & e.m);
    end
    // ceiling well above the roughly seven to eight hundred cycles the scenarios need
    if (cyc == 6000) begin
      n_errors++;
      conclude();
    end
  end

  task automatic tick(input int c);
    repeat (c) @(posedge clk_sys);
  endtask

  task automatic note(input logic [1:0] k, input logic [31:0] v, input logic [31:0] m);
    q.push_back('{k, v, m});
    chk <= 1'b1;
    tick(1);
    chk <= 1'b0;
    tick(1);
  endtask

  // high and low well above the one-clock minimum of the pin filter
  task automatic pulses(input int c);
    repeat (c) begin
      cp <= 1'b1;
      tick(3);
      cp <= 1'b0;
      tick(3);
    end
  endtask

  task automatic drive_in(input logic b);
    dip <= b;
    tick(6);
  endtask

  task automatic gate(input logic b);
    req.program_gate_bit <= b;
    tick(5);
  endtask

  task automatic load(input logic [31:0] v, input logic direct);
    req.load_value <= v;
    req.load_direct <= direct;
    req.load_prepare <= !direct;
    tick(1);
    req.load_direct <= 1'b0;
    req.load_prepare <= 1'b0;
    tick(4);
  endtask

  task automatic restart(input pcg_di_func_t f, input logic cancel, input logic per,
                         input logic iso = 1'b0);
    srst <= 1'b1;
    req <= '0;
    cfg <= '{f, cancel, 1'b0, per, iso, 1'b1};
    tick(8);
    srst <= 1'b0;
    ld_v = $random(seed) & 32'h00FF_FFFF;
    n = 1 + ($random(seed) & 3);
    tick(1);
  endtask

  initial begin
    seed = 78;
    cp = 1'b0;
    dir = 1'b0;
    dip = 1'b0;
    shrt = 1'b0;
    chk = 1'b0;
    restart(PCG_DI_INPUT, 1'b1, 1'b0);
    for (int k = 0; k < 3; k++) note(k[1:0], 32'h0, '1);
    load(ld_v, 1'b0);
    gate(1'b1);
    pulses(n);
    note(2'd2, ld_v + n, '1);
    note(2'd0, ld_v + n, '1);
    note(2'd1, 32'h0041_0000, '1);
    gate(1'b0);
    pulses(2);
    note(2'd2, ld_v + n, '1);
    gate(1'b1);
    pulses(1);
    note(2'd2, ld_v + 1, '1);
    restart(PCG_DI_INPUT, 1'b0, 1'b0);
    shrt <= 1'b1;
    load(32'h0100_0000, 1'b0);
    note(2'd1, 32'h8200_0000, 32'hFF00_0000);
    shrt <= 1'b0;
    load(ld_v, 1'b0);
    gate(1'b1);
    pulses(n);
    gate(1'b0);
    gate(1'b1);
    pulses(1);
    note(2'd2, n + 1, '1);
    dir <= 1'b1;
    pulses(n + 2);
    note(2'd2, 32'hFFFF_FFFF, '1);
    note(2'd1, 32'h0081_8000, 32'h00C1_8000);
    dir <= 1'b0;
    restart(PCG_DI_LATCH, 1'b1, 1'b0);
    load(ld_v, 1'b0);
    gate(1'b1);
    pulses(n);
    drive_in(1'b1);
    note(2'd1, 32'h0002_0000, 32'h0002_0000);
    drive_in(1'b0);
    note(2'd0, ld_v + n, '1);
    load(32'h0000_0055, 1'b1);
    note(2'd0, ld_v + n, '1);
    note(2'd2, 32'h0000_0055, '1);
    load(ld_v, 1'b0);
    gate(1'b0);
    gate(1'b1);
    note(2'd2, ld_v, '1);
    restart(PCG_DI_LATCH_RETRIG, 1'b0, 1'b0);
    load(ld_v, 1'b0);
    drive_in(1'b1);
    drive_in(1'b0);
    gate(1'b1);
    note(2'd0, 32'h0, '1);
    note(2'd2, 32'h0, '1);
    load(32'h0000_0100, 1'b1);
    load(ld_v, 1'b0);
    pulses(n);
    drive_in(1'b1);
    drive_in(1'b0);
    note(2'd0, 32'h100 + n, '1);
    pulses(2);
    gate(1'b0);
    drive_in(1'b1);
    drive_in(1'b0);
    note(2'd0, ld_v + 2, '1);
    gate(1'b1);
    pulses(1);
    note(2'd2, ld_v + 1, '1);
    for (int p = 1; p >= 0; p--) begin
      restart(PCG_DI_SYNC, 1'b0, p[0]);
      load(ld_v, 1'b0);
      gate(1'b1);
      pulses(n);
      drive_in(1'b1);
      drive_in(1'b0);
      note(2'd2, n, '1);
      req.sync_enable_bit <= 1'b1;
      tick(3);
      drive_in(1'b1);
      drive_in(1'b0);
      pulses(2);
      drive_in(1'b1);
      drive_in(1'b0);
      note(2'd2, p ? ld_v : ld_v + 2, '1);
      note(2'd1, 32'h0000_0100, 32'h0000_0100);
      req.status_clear_request <= 1'b1;
      tick(4);
      note(2'd1, 32'h0400_0000, 32'h0400_0100);
      req.status_clear_request <= 1'b0;
      tick(2);
    end
    restart(PCG_DI_PIN_GATE, 1'b1, 1'b0);
    load(ld_v, 1'b0);
    drive_in(1'b1);
    gate(1'b1);
    pulses(n);
    note(2'd2, n, '1);
    drive_in(1'b0);
    drive_in(1'b1);
    pulses(1);
    note(2'd2, ld_v + 1, '1);
    note(2'd1, 32'h0043_0000, '1);
    // iso: a program gate opened against an open pin gate waits for the instant
    restart(PCG_DI_PIN_GATE, 1'b0, 1'b0, 1'b1);
    drive_in(1'b1);
    gate(1'b1);
    pulses(2);
    tick(30);
    pulses(1);
    note(2'd2, 32'h0, '1);
    tick(40);
    note(2'd2, 32'h1, '1);
    note(2'd1, 32'h0043_0000, '1);
    conclude();
  end
endmodule
